// [shared/ists_pkg.sv]
// constants and carrier types of the two-wire slave port with bus timeout
// assumes a 200 MHz system clock and a 32.768 kHz timebase tick input
package ists_pkg;
  localparam logic [6:0] ADDR_7BIT = 7'h51; // 1010001b, write byte A2h, read byte A3h
  localparam logic [7:0] IDLE_BYTE = 8'hFF; // returned on reads once timed out
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam int TIMEOUT_MS = 950;
  localparam int TICK_HZ = 32768;
  // ticks of the 32.768 kHz base that make up the timeout
  localparam int TIMEOUT_TICKS = (TIMEOUT_MS * TICK_HZ) / 1000;
  localparam int TO_W = 15;
  localparam logic [TO_W-1:0] TIMEOUT_LIMIT = TO_W'(TIMEOUT_TICKS);
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_W = 16;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  typedef enum logic [2:0] {
    ISTS_IDLE = 3'b000,
    ISTS_ADDR = 3'b001,
    ISTS_REG = 3'b010,
    ISTS_WDATA = 3'b011,
    ISTS_RDATA = 3'b100,
    ISTS_DEAD = 3'b101
  } ists_state_t;

  // register write leaving the port towards the register file
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } ists_wr_t;
endpackage

// [hdl/ists_fifo.sv]
// parameterised valid/ready FIFO for register writes
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/100ps
module ists_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  wire push = in_valid_in && (cnt != (AW+1)'(DEPTH));
  wire pop = out_ready_in && (cnt != '0);

  // flags straight from the count
  assign in_ready_out = cnt != (AW+1)'(DEPTH);
  assign out_valid_out = cnt != '0;
  assign out_data_out = mem[rp];

  // pointers and occupancy
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
      if (pop) rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk_sys_in) begin
    if (push) mem[wp] <= in_data_in;
  end
endmodule

// [hdl/ists_slave.sv]
// two-wire bus slave with bus timeout, register pointer and write FIFO
// assumes scl/sda arrive asynchronously; tick_in is a one-cycle 32.768 kHz pulse in this domain
`timescale 1ns/100ps
module ists_slave (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // timebase
  input wire logic tick_in,
  // bus pins; oe active low
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oen_out,
  // register read data for the current pointer
  output logic [7:0] rd_addr_out,
  input wire logic [7:0] rd_data_in,
  // register writes
  output logic wr_valid_out,
  output ists_pkg::ists_wr_t wr_out,
  input wire logic wr_ready_in,
  // status
  output logic busy_out,
  output logic timeout_out
);
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic scl_d;
  logic sda_d;
  ists_pkg::ists_state_t state;
  logic [3:0] bitn;
  logic [7:0] shreg;
  logic [7:0] ptr;
  logic [7:0] txb;
  logic drive_low;
  logic ack_due;
  logic nacked;
  logic [ists_pkg::TO_W-1:0] to_cnt;
  logic in_txn;
  logic timed_out;
  logic fifo_in_ready;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end

  // 200 MHz sampling leaves about 250 clocks per 400 kHz half period
  // edge and condition decode from the second stage and its one-clock delayed copy
  wire scl = scl_s[1];
  wire sda = sda_s[1];
  wire scl_rise = scl && !scl_d;
  wire scl_fall = !scl && scl_d;
  wire start_c = scl && scl_d && sda_d && !sda;
  wire stop_c = scl && scl_d && !sda_d && sda;
  wire byte_done = scl_rise && (bitn == ists_pkg::BIT_LAST);
  wire [7:0] rx_byte = {shreg[6:0], sda};
  wire addr_hit = rx_byte[7:1] == ists_pkg::ADDR_7BIT;
  wire fifo_push = (state == ists_pkg::ISTS_WDATA) && byte_done;
  // bytes the slave acks; a full fifo refuses the data byte
  wire next_ack_due = (state == ists_pkg::ISTS_ADDR && addr_hit) || (state == ists_pkg::ISTS_REG) ||
                      (state == ists_pkg::ISTS_WDATA && fifo_in_ready);
  // master's slot after a read byte; the address ack is the slave's own
  wire mst_ack_slot = (state == ists_pkg::ISTS_RDATA) && scl_rise && (bitn == ists_pkg::BIT_ACK) && !ack_due;
  wire to_hit = in_txn && tick_in && (to_cnt == ists_pkg::TIMEOUT_LIMIT - 1'b1);
  // dead port reads as all ones
  wire [7:0] next_txb = timed_out ? ists_pkg::IDLE_BYTE : rd_data_in;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      to_cnt <= '0;
      in_txn <= 1'b0;
    end else if (start_c) begin
      to_cnt <= '0;
      in_txn <= 1'b1;
    end else if (stop_c || to_hit) begin
      to_cnt <= '0;
      in_txn <= 1'b0;
    end else if (in_txn && tick_in) begin
      to_cnt <= to_cnt + 1'b1;
    end
  end

  // timeout flag; only START clears it
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) timed_out <= 1'b0;
    else if (to_hit) timed_out <= 1'b1;
    else if (start_c) timed_out <= 1'b0;
  end

  // bit counter and shift register; sample on clock rise
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bitn <= 4'h0;
      shreg <= 8'h00;
    end else if (start_c) begin
      // preset so the clock fall that ends START lands on bit 0
      bitn <= ists_pkg::BIT_ACK;
    end else if (scl_rise) begin
      shreg <= rx_byte;
    end else if (scl_fall) begin
      bitn <= (bitn == ists_pkg::BIT_ACK) ? 4'h0 : bitn + 1'b1;
    end
  end

  // byte-level state machine
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= ists_pkg::ISTS_IDLE;
      nacked <= 1'b0;
    end else if (start_c) begin
      // repeated start restarts; address byte follows
      state <= ists_pkg::ISTS_ADDR;
      nacked <= 1'b0;
    end else if (stop_c) begin
      state <= ists_pkg::ISTS_IDLE;
    end else if (to_hit) begin
      state <= ists_pkg::ISTS_DEAD;
    end else begin
      case (state)
        ists_pkg::ISTS_ADDR: begin
          if (byte_done) begin
            // direction bit picks read or write
            if (!addr_hit) state <= ists_pkg::ISTS_IDLE;
            else if (rx_byte[0]) state <= ists_pkg::ISTS_RDATA;
            else state <= ists_pkg::ISTS_REG;
          end
        end
        ists_pkg::ISTS_REG: begin
          if (byte_done) state <= ists_pkg::ISTS_WDATA;
        end
        ists_pkg::ISTS_RDATA: begin
          if (mst_ack_slot && sda) begin
            nacked <= 1'b1;
            state <= ists_pkg::ISTS_IDLE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ack decision latched at the eighth rise and spent at the next fall;
  // latching it keeps a full fifo from being acked after a pop slips in
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) ack_due <= 1'b0;
    else if (start_c || stop_c || to_hit) ack_due <= 1'b0;
    else if (byte_done) ack_due <= next_ack_due;
  end

  // pointer; untouched by stop and timeout
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ptr <= ists_pkg::PTR_RESET;
    end else if (state == ists_pkg::ISTS_REG && byte_done) begin
      ptr <= rx_byte;
    end else if (fifo_push && fifo_in_ready) begin
      ptr <= ptr + 8'h01;
    end else if (mst_ack_slot) begin
      // advance per read byte, the nacked last one too
      ptr <= ptr + 8'h01;
    end
  end

  // data line drive, set only on falling clock; start, stop or timeout release it at once
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      drive_low <= 1'b0;
      txb <= ists_pkg::IDLE_BYTE;
    end else if (start_c || stop_c || to_hit) begin
      drive_low <= 1'b0;
    end else if (scl_fall) begin
      // drive only for ack or transmit
      if (bitn == ists_pkg::BIT_LAST) begin
        // ack slot, no ack when timed out
        drive_low <= !timed_out && ack_due;
      end else if (state == ists_pkg::ISTS_RDATA && !nacked) begin
        if (bitn == ists_pkg::BIT_ACK) begin
          txb <= {next_txb[6:0], 1'b1};
          drive_low <= !next_txb[7];
        end else begin
          txb <= {txb[6:0], 1'b1};
          drive_low <= !txb[7];
        end
      end else begin
        drive_low <= 1'b0;
      end
    end
  end

  ists_fifo #(
    .WIDTH(ists_pkg::FIFO_W),
    .DEPTH(ists_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .in_valid_in(fifo_push && !timed_out),
    .in_data_in({ptr, rx_byte}),
    .in_ready_out(fifo_in_ready),
    .out_valid_out(wr_valid_out),
    .out_data_out(wr_out),
    .out_ready_in(wr_ready_in)
  );

  // registered outputs
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sda_out <= 1'b1;
      sda_oen_out <= 1'b1;
      rd_addr_out <= ists_pkg::PTR_RESET;
      busy_out <= 1'b0;
      timeout_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
      sda_oen_out <= !drive_low;
      rd_addr_out <= ptr;
      busy_out <= in_txn;
      timeout_out <= timed_out;
    end
  end

  AST_IDLE_RELEASE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    state == ists_pkg::ISTS_IDLE |=> ##1 sda_oen_out)
    else $error("data line driven while idle");
  AST_DEAD_QUIET: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    timed_out |-> ##2 sda_oen_out)
    else $error("drive after timeout");
  AST_TO_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (timed_out && !start_c) |=> timed_out)
    else $error("timeout flag lost without start");
  AST_PTR_STOP: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    stop_c |=> $stable(ptr))
    else $error("pointer changed on stop");
  AST_TO_CLR: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    stop_c |=> (to_cnt == '0 && !in_txn))
    else $error("timeout counter not cleared");
  AST_TO_FIRE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    to_hit && !start_c && !stop_c |=> (timed_out && state == ists_pkg::ISTS_DEAD) ##1 timeout_out)
    else $error("timeout not taken");
  AST_RESTART: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    start_c |=> (state == ists_pkg::ISTS_ADDR && bitn == ists_pkg::BIT_ACK))
    else $error("start did not restart");
  AST_PTR_LOAD: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state == ists_pkg::ISTS_REG && byte_done && !start_c && !stop_c) |=> ptr == $past(rx_byte))
    else $error("pointer not loaded");
  // every read byte moves the pointer on
  AST_RD_ADVANCE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    mst_ack_slot |=> ptr == $past(ptr) + 8'h01)
    else $error("read pointer did not advance");
  // foreign address drops the port to idle
  AST_FOREIGN_IDLE: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    (state == ists_pkg::ISTS_ADDR && byte_done && !addr_hit && !to_hit) |=>
    (state == ists_pkg::ISTS_IDLE && !ack_due))
    else $error("foreign address not ignored");
  // own address seen on the eighth rise
  sequence seq_addr_hit;
    state == ists_pkg::ISTS_ADDR && byte_done && addr_hit && !to_hit;
  endsequence
  // own address is acknowledged in the next slot
  AST_ADDR_ACK: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
    seq_addr_hit |=> ack_due)
    else $error("own address not acknowledged");
endmodule

// [verification/ists_bus_master.sv]
// bus master model driving the clock line and pulling the data line
// assumes a pull-up on the data line; the bench resolves the wire level
`timescale 1ns/100ps
module ists_bus_master (
  // clock
  input wire logic clk_sys_in,
  // bus lines
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_pull_out
);
  // idle bus: both lines released high
  initial begin
    scl_out = 1'b1;
    sda_pull_out = 1'b0;
  end
  // every change lands just after a system clock edge
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // start from idle or after a low clock
  task automatic start();
    sda_pull_out <= 1'b0;
    tk(8);
    scl_out <= 1'b1;
    tk(16);
    sda_pull_out <= 1'b1;
    tk(16);
    scl_out <= 1'b0;
    tk(8);
  endtask
  // stop closes the frame, clock then stands still high
  task automatic stop();
    sda_pull_out <= 1'b1;
    tk(8);
    scl_out <= 1'b1;
    tk(16);
    sda_pull_out <= 1'b0;
    tk(16);
  endtask
  // one bit per 160 ns clock period, data moved only while clock low
  task automatic bitx(input logic b, output logic s);
    sda_pull_out <= !b;
    tk(8);
    scl_out <= 1'b1;
    tk(15);
    s = sda_in;
    tk(1);
    scl_out <= 1'b0;
    tk(8);
  endtask
  // msb first, ninth bit: master acks unless last read
  task automatic xbyte(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], rx[i]);
    end
    bitx(!mack, s);
    ack = !s;
  endtask
endmodule

// [verification/ists_slave_test.sv]
// self-checking bench for the two-wire slave port
// assumes the bus master model and a register file stand-in from rd_addr_out
`timescale 1ns/100ps
module ists_slave_test;
  logic clk_sys_in, rstn_in, tick_in, wr_ready_in, sda_out, sda_oen_out, wr_valid_out;
  logic busy_out, timeout_out, scl, pull, sda, ack, tick_all, stall, e;
  logic [7:0] rd_data_in, rd_addr_out, rx, d, q, key;
  ists_pkg::ists_wr_t wr_out;
  int err_count, checks_done, ptr;
  logic [15:0] exp_q[$];
  // open-drain wire: low if either party pulls, else pulled up
  assign sda = !(pull || (!sda_oen_out && !sda_out));
  assign rd_data_in = rd_addr_out ^ key;
  ists_slave dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .tick_in(tick_in), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oen_out(sda_oen_out), .rd_addr_out(rd_addr_out),
    .rd_data_in(rd_data_in), .wr_valid_out(wr_valid_out), .wr_out(wr_out), .wr_ready_in(wr_ready_in),
    .busy_out(busy_out), .timeout_out(timeout_out));
  ists_bus_master m (.clk_sys_in(clk_sys_in), .sda_in(sda), .scl_out(scl), .sda_pull_out(pull));
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = !clk_sys_in;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // random timebase and random stalls of the write consumer
  always @(posedge clk_sys_in) begin
    tick_in <= tick_all || ($urandom % 64 == 0);
    wr_ready_in <= !stall && ($urandom % 4 != 0);
  end
  // every write leaving the fifo is compared with the model queue
  always @(posedge clk_sys_in) begin
    if (wr_valid_out === 1'b1 && wr_ready_in === 1'b1) begin
      chk("fifo empty at pop", 16'h1, 16'(exp_q.size() > 0));
      if (exp_q.size() > 0) chk("register write", exp_q.pop_front(), wr_out);
    end
  end
  // address byte then register byte, then n data bytes
  task automatic wr_seq(input logic [7:0] r, input int n, input logic stop_it);
    m.start();
    m.xbyte(8'hA2, 1'b0, rx, ack);
    chk("write address ack", 16'h1, 16'(ack));
    m.xbyte(r, 1'b0, rx, ack);
    chk("pointer byte ack", 16'h1, 16'(ack));
    ptr = r;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      e = !(stall && exp_q.size() >= ists_pkg::FIFO_DEPTH);
      if (e) begin
        exp_q.push_back({8'(ptr), d});
        ptr++;
      end
      m.xbyte(d, 1'b0, rx, ack);
      chk("data ack", 16'(e), 16'(ack));
    end
    if (stop_it) m.stop();
  endtask
  // n read bytes, last one not acknowledged
  task automatic rd_bytes(input int n);
    for (int i = 0; i < n; i++) begin
      m.xbyte(8'hFF, i < n - 1, rx, ack);
      chk("read data", 16'(8'(ptr) ^ key), 16'(rx));
      ptr++;
    end
  endtask
  initial begin
    rstn_in = 1'b0;
    tick_in = 1'b0;
    wr_ready_in = 1'b0;
    tick_all = 1'b0;
    stall = 1'b0;
    void'($urandom(19));
    key = 8'($urandom);
    repeat (10) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    m.tk(8);
    wr_seq(8'($urandom), 3, 1'b0);
    chk("busy in frame", 16'h1, 16'(busy_out));
    m.stop();
    m.tk(8);
    chk("busy after stop", 16'h0, 16'(busy_out));
    m.start();
    m.xbyte(8'hA3, 1'b0, rx, ack);
    chk("read address ack", 16'h1, 16'(ack));
    rd_bytes(2);
    m.stop();
    q = 8'($urandom);
    wr_seq(q, 0, 1'b0);
    m.start();
    m.xbyte(8'hA3, 1'b0, rx, ack);
    chk("ack after repeated start", 16'h1, 16'(ack));
    rd_bytes(3);
    m.stop();
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      if (d[7:1] == ists_pkg::ADDR_7BIT) d = d ^ 8'h80;
      m.start();
      m.xbyte(d, 1'b0, rx, ack);
      chk("foreign address nack", 16'h0, 16'(ack));
      m.xbyte(8'hFF, 1'b0, rx, ack);
      chk("line left released", 16'hFF, 16'(rx));
      m.stop();
    end
    stall = 1'b1;
    wr_seq(8'hFC, ists_pkg::FIFO_DEPTH + 1, 1'b1);
    stall = 1'b0;
    m.tk(100);
    chk("fifo drained", 16'h0, 16'(exp_q.size()));
    chk("valid low when empty", 16'h0, 16'(wr_valid_out));
    m.start();
    tick_all = 1'b1;
    m.tk(4);
    m.xbyte(8'hA2, 1'b0, rx, ack);
    m.xbyte(q, 1'b0, rx, ack);
    exp_q.push_back({q, 8'h3C});
    m.xbyte(8'h3C, 1'b0, rx, ack);
    chk("data ack before timeout", 16'h1, 16'(ack));
    m.tk(ists_pkg::TIMEOUT_TICKS - 1000);
    chk("no early timeout", 16'h0, 16'(timeout_out));
    m.tk(1100);
    chk("timeout raised", 16'h1, 16'(timeout_out));
    tick_all = 1'b0;
    m.xbyte(8'h11, 1'b0, rx, ack);
    chk("no ack after timeout", 16'h0, 16'(ack));
    m.xbyte(8'hFF, 1'b1, rx, ack);
    chk("all ones after timeout", 16'hFF, 16'(rx));
    m.stop();
    m.start();
    m.xbyte(8'hA3, 1'b0, rx, ack);
    chk("ack after fresh start", 16'h1, 16'(ack));
    chk("timeout cleared", 16'h0, 16'(timeout_out));
    ptr = q + 8'h01;
    rd_bytes(1);
    m.stop();
    m.start();
    m.xbyte(8'hA3, 1'b0, rx, ack);
    chk("ack on bare read", 16'h1, 16'(ack));
    rd_bytes(1);
    m.stop();
    m.tk(50);
    chk("writes all seen", 16'h0, 16'(exp_q.size()));
    wrap_up();
  end
  // watchdog well beyond the longest test path
  initial begin
    repeat (80000) @(posedge clk_sys_in);
    err_count++;
    wrap_up();
  end
endmodule
